// ### logic/dev_ctrl_pkg.sv
// Contract
// - Device reset with permit set returns controller near power-up
// - Device reset bit clears itself
// - Device reset raises reset cause interrupt
// - Global reset only when permit bit set
// - Device reset sets reset-occurred status flag
// - Tag strip enable removes received VLAN tags
// - PHY reset bit holds PHY in reset
// - Status register read-only at its offset
// - Status bit zero shows MAC duplex
// - Status bit one shows link up
// - Link up follows PHY link indication in internal PHY mode with SLU set
// - Tx paused set on XOFF frame while flow control active
// - Tx paused cleared on timer or XON
package dev_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  CTRL_OFF       = 8'h00;
    localparam logic [7:0]  STATUS_OFF     = 8'h08;
    localparam logic [7:0]  IRQ_STAT_OFF   = 8'hc0;
    localparam logic [7:0]  IRQ_CLR_OFF    = 8'hc4;
    localparam logic [7:0]  IRQ_EN_OFF     = 8'hc8;

    // ==========================================================
    // Control fields
    localparam int          CTRL_SLU_BIT   = 0;
    localparam int          CTRL_DRST_BIT  = 29;
    localparam int          CTRL_STRIP_BIT = 30;
    localparam int          CTRL_PRST_BIT  = 31;

    // ==========================================================
    // Status fields
    localparam int          ST_DUPLEX_BIT  = 0;
    localparam int          ST_LINK_BIT    = 1;
    localparam int          ST_TX_PAUSED_FLAG_BIT   = 4;
    localparam int          ST_RSTOCC_BIT  = 11;

    // ==========================================================
    // Interrupt cause fields
    localparam int          IRQ_W          = 3;
    localparam int          IRQ_DRST_BIT   = 0;
    localparam int          IRQ_LINK_BIT   = 1;
    localparam int          IRQ_TX_PAUSED_FLAG_BIT  = 2;
    localparam logic [2:0]  IRQ_EN_RESET   = 3'h0;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          RESET_HOLD_NS  = 100;
    localparam int          RESET_HOLD_CYC =
        (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CNT_W          = 5;

endpackage

// ### logic/rst_seq_if.sv
`timescale 1ns/1ps
interface rst_seq_if;
    logic start;
    logic permit;
    logic pulse;
    logic busy;
    logic done;

    modport seq (input start, input permit, output pulse, output busy, output done);
    modport ctrl (output start, output permit, input pulse, input busy, input done);
endinterface

// ### logic/dev_reset_seq.sv
`timescale 1ns/1ps
module dev_reset_seq (
    input  wire logic  clk,
    input  wire logic  reset_n,
    rst_seq_if.seq     sq
);
    typedef enum logic {SEQ_IDLE, SEQ_HOLD} seq_state_t;

    seq_state_t                        state_reg;
    seq_state_t                        state_next;
    logic [dev_ctrl_pkg::CNT_W-1:0]    count_reg;
    logic [dev_ctrl_pkg::CNT_W-1:0]    count_next;
    logic                              permit_reg;
    logic                              permit_next;
    logic                              done_reg;
    logic                              done_next;
    logic                              pulse_reg;
    logic                              pulse_next;

    localparam logic [dev_ctrl_pkg::CNT_W-1:0] LAST =
        dev_ctrl_pkg::CNT_W'(dev_ctrl_pkg::RESET_HOLD_CYC - 1);

    // ==========================================================
    // Reset hold sequence
    always_comb begin
        state_next  = state_reg;
        count_next  = count_reg;
        permit_next = permit_reg;
        done_next   = 1'b0;
        pulse_next  = pulse_reg;
        unique case (state_reg)
            SEQ_IDLE: begin
                if (sq.start) begin
                    state_next  = SEQ_HOLD;
                    count_next  = '0;
                    permit_next = sq.permit;
                    pulse_next  = sq.permit;
                end
            end
            SEQ_HOLD: begin
                count_next = count_reg + 1'b1;
                if (count_reg == LAST) begin
                    state_next = SEQ_IDLE;
                    pulse_next = 1'b0;
                    done_next  = permit_reg;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= SEQ_IDLE;
            count_reg  <= '0;
            permit_reg <= 1'b0;
            done_reg   <= 1'b0;
            pulse_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            permit_reg <= permit_next;
            done_reg   <= done_next;
            pulse_reg  <= pulse_next;
        end
    end

    assign sq.busy  = (state_reg == SEQ_HOLD);
    assign sq.pulse = pulse_reg;
    assign sq.done  = done_reg;
endmodule

// ### logic/device_ctrl_status_bits.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module device_ctrl_status_bits (
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire logic [dev_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [31:0]                     reg_rdata,
    input  wire logic                            device_reset_permit,
    input  wire logic                            mac_full_duplex,
    input  wire logic                            internal_phy_mode,
    input  wire logic                            phy_link_pin,
    input  wire logic                            flow_ctrl_active,
    input  wire logic                            xoff_rcvd,
    input  wire logic                            xon_rcvd,
    input  wire logic                            pause_expired,
    output logic                                 dev_reset_out,
    output logic                                 phy_reset_out,
    output logic                                 tag_strip_out,
    output logic                                 irq
);
    rst_seq_if sq ();

    logic                               link_meta_reg;
    logic                               link_sync_reg;
    logic                               link_up_reg;
    logic                               link_up_next;
    logic                               strip_reg;
    logic                               strip_next;
    logic                               phy_reset_bit_reg;
    logic                               phy_reset_bit_next;
    logic                               slu_reg;
    logic                               slu_next;
    logic                               tx_paused_flag_reg;
    logic                               tx_paused_flag_next;
    logic                               rst_occ_reg;
    logic                               rst_occ_next;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_stat_reg;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_stat_next;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_en_reg;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_en_next;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_evt;
    logic [dev_ctrl_pkg::IRQ_W-1:0]     irq_clr;
    logic [31:0]                        rdata_reg;
    logic [31:0]                        rdata_next;
    logic                               irq_reg;
    logic                               irq_next;
    logic                               ctrl_wr;
    logic                               dev_start;

    // ==========================================================
    // PHY link pin synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link_meta_reg <= 1'b0;
            link_sync_reg <= 1'b0;
        end else begin
            link_meta_reg <= phy_link_pin;
            link_sync_reg <= link_meta_reg;
        end
    end

    // ==========================================================
    // Device reset sequencer
    assign ctrl_wr   = reg_wr && (reg_addr == dev_ctrl_pkg::CTRL_OFF);
    assign dev_start = ctrl_wr && reg_wdata[dev_ctrl_pkg::CTRL_DRST_BIT] && !sq.busy;
    assign sq.start  = dev_start;
    assign sq.permit = device_reset_permit;

    dev_reset_seq u_seq (
        .clk     (clk),
        .reset_n (reset_n),
        .sq      (sq)
    );

    // ==========================================================
    // Control and status state
    always_comb begin
        strip_next   = strip_reg;
        phy_reset_bit_next = phy_reset_bit_reg;
        slu_next     = slu_reg;
        irq_en_next  = irq_en_reg;
        tx_paused_flag_next   = tx_paused_flag_reg;
        rst_occ_next = rst_occ_reg || dev_start;
        if (ctrl_wr) begin
            strip_next   = reg_wdata[dev_ctrl_pkg::CTRL_STRIP_BIT];
            phy_reset_bit_next = reg_wdata[dev_ctrl_pkg::CTRL_PRST_BIT];
            slu_next     = reg_wdata[dev_ctrl_pkg::CTRL_SLU_BIT];
        end
        if (reg_wr && (reg_addr == dev_ctrl_pkg::IRQ_EN_OFF)) begin
            irq_en_next = reg_wdata[dev_ctrl_pkg::IRQ_W-1:0];
        end
        if (xoff_rcvd && flow_ctrl_active) begin
            tx_paused_flag_next = 1'b1;
        end else if (xon_rcvd || pause_expired) begin
            tx_paused_flag_next = 1'b0;
        end
        if (sq.done) begin
            strip_next   = 1'b0;
            phy_reset_bit_next = 1'b0;
            slu_next     = 1'b0;
            irq_en_next  = dev_ctrl_pkg::IRQ_EN_RESET;
            tx_paused_flag_next   = 1'b0;
        end
        link_up_next = internal_phy_mode && slu_reg && link_sync_reg;
    end

    // ==========================================================
    // Interrupt cause, clear and enable
    always_comb begin
        irq_evt = '0;
        irq_evt[dev_ctrl_pkg::IRQ_DRST_BIT]  = dev_start;
        irq_evt[dev_ctrl_pkg::IRQ_LINK_BIT]  = link_up_next != link_up_reg;
        irq_evt[dev_ctrl_pkg::IRQ_TX_PAUSED_FLAG_BIT] = tx_paused_flag_next && !tx_paused_flag_reg;
        irq_clr = '0;
        if (reg_wr && (reg_addr == dev_ctrl_pkg::IRQ_CLR_OFF)) begin
            irq_clr = reg_wdata[dev_ctrl_pkg::IRQ_W-1:0];
        end
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;
        irq_next      = |(irq_stat_reg & irq_en_reg);
    end

    // ==========================================================
    // Read port
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                dev_ctrl_pkg::CTRL_OFF: begin
                    rdata_next[dev_ctrl_pkg::CTRL_SLU_BIT]   = slu_reg;
                    rdata_next[dev_ctrl_pkg::CTRL_DRST_BIT]  = sq.busy;
                    rdata_next[dev_ctrl_pkg::CTRL_STRIP_BIT] = strip_reg;
                    rdata_next[dev_ctrl_pkg::CTRL_PRST_BIT]  = phy_reset_bit_reg;
                end
                dev_ctrl_pkg::STATUS_OFF: begin
                    rdata_next[dev_ctrl_pkg::ST_DUPLEX_BIT] = mac_full_duplex;
                    rdata_next[dev_ctrl_pkg::ST_LINK_BIT]   = link_up_reg;
                    rdata_next[dev_ctrl_pkg::ST_TX_PAUSED_FLAG_BIT]  = tx_paused_flag_reg;
                    rdata_next[dev_ctrl_pkg::ST_RSTOCC_BIT] = rst_occ_reg;
                end
                dev_ctrl_pkg::IRQ_STAT_OFF: begin
                    rdata_next[dev_ctrl_pkg::IRQ_W-1:0] = irq_stat_reg;
                end
                dev_ctrl_pkg::IRQ_EN_OFF: begin
                    rdata_next[dev_ctrl_pkg::IRQ_W-1:0] = irq_en_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strip_reg    <= 1'b0;
            phy_reset_bit_reg  <= 1'b0;
            slu_reg      <= 1'b0;
            tx_paused_flag_reg    <= 1'b0;
            rst_occ_reg  <= 1'b0;
            link_up_reg  <= 1'b0;
            irq_stat_reg <= '0;
            irq_en_reg   <= dev_ctrl_pkg::IRQ_EN_RESET;
            irq_reg      <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            strip_reg    <= strip_next;
            phy_reset_bit_reg  <= phy_reset_bit_next;
            slu_reg      <= slu_next;
            tx_paused_flag_reg    <= tx_paused_flag_next;
            rst_occ_reg  <= rst_occ_next;
            link_up_reg  <= link_up_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg   <= irq_en_next;
            irq_reg      <= irq_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata     = rdata_reg;
    assign irq           = irq_reg;
    assign dev_reset_out = sq.pulse;
    assign phy_reset_out = phy_reset_bit_reg;
    assign tag_strip_out = strip_reg;

    // ==========================================================
    // Assertion helper: length of the running global reset pulse
    localparam logic [dev_ctrl_pkg::CNT_W-1:0] HOLD_LEN =
        dev_ctrl_pkg::CNT_W'(dev_ctrl_pkg::RESET_HOLD_CYC);

    logic [dev_ctrl_pkg::CNT_W-1:0]     pulse_len_reg;
    logic [dev_ctrl_pkg::CNT_W-1:0]     pulse_len_next;

    always_comb begin
        pulse_len_next = '0;
        if (dev_reset_out) begin
            pulse_len_next = pulse_len_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_len_reg <= '0;
        end else begin
            pulse_len_reg <= pulse_len_next;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_rst_self_clear: assert property (
        dev_start |-> ##1 sq.busy ##19 sq.busy ##1 !sq.busy)
        else $error("device reset bit did not clear after hold");

    a_rst_reads_done: assert property (
        sq.busy ##1 (reg_rd && reg_addr == dev_ctrl_pkg::CTRL_OFF && !sq.busy)
        |=> !reg_rdata[dev_ctrl_pkg::CTRL_DRST_BIT])
        else $error("device reset bit read one after completion");

    a_rst_pulse_permit: assert property (
        dev_start |=> ##20 !dev_reset_out
            && pulse_len_reg == ($past(device_reset_permit, 21) ? HOLD_LEN : '0))
        else $error("device reset output disagrees with permit");

    a_rst_clears_ctrl: assert property (
        sq.done |=> !tag_strip_out && !phy_reset_out && irq_en_reg == '0)
        else $error("control state survived device reset");

    a_rst_cause_set: assert property (
        dev_start |=> irq_stat_reg[dev_ctrl_pkg::IRQ_DRST_BIT])
        else $error("device reset cause not set");

    a_rst_flag_set: assert property (
        dev_start |=> rst_occ_reg ##1 rst_occ_reg)
        else $error("reset occurred flag not set");

    a_strip_follows: assert property (
        ctrl_wr && !sq.done |=> tag_strip_out == $past(reg_wdata[dev_ctrl_pkg::CTRL_STRIP_BIT]))
        else $error("tag strip output does not follow control write");

    a_phy_reset_bit_follows: assert property (
        ctrl_wr && !sq.done |=> phy_reset_out == $past(reg_wdata[dev_ctrl_pkg::CTRL_PRST_BIT]))
        else $error("phy reset output does not follow control write");

    a_status_read: assert property (
        reg_rd && reg_addr == dev_ctrl_pkg::STATUS_OFF
        |=> reg_rdata[0] == $past(mac_full_duplex) && reg_rdata[3:2] == 2'h0 && !reg_rdata[5])
        else $error("status read returned wrong duplex or reserved bits");

    a_link_follows: assert property (
        internal_phy_mode && slu_reg && $rose(link_sync_reg) |=> link_up_reg)
        else $error("link up did not follow phy link");

    a_tx_paused_flag_set: assert property (
        xoff_rcvd && flow_ctrl_active && !sq.done |=> tx_paused_flag_reg)
        else $error("tx paused not set on xoff");

    a_tx_paused_flag_clear: assert property (
        (xon_rcvd || pause_expired) && !(xoff_rcvd && flow_ctrl_active) |=> !tx_paused_flag_reg)
        else $error("tx paused not cleared");

    a_irq_level: assert property (
        irq == $past(|(irq_stat_reg & irq_en_reg)))
        else $error("interrupt level disagrees with enabled causes");

    a_link_gated: assert property (
        !(internal_phy_mode && slu_reg) |=> !link_up_reg)
        else $error("link up shown without internal phy and forced link");

    a_link_drops: assert property (
        $fell(link_sync_reg) |=> !link_up_reg)
        else $error("link up did not drop with phy link");

    a_tx_paused_flag_holds: assert property (
        !(xoff_rcvd && flow_ctrl_active) && !xon_rcvd && !pause_expired && !sq.done
        |=> tx_paused_flag_reg == $past(tx_paused_flag_reg))
        else $error("tx paused changed without an event");

    a_occ_sticky: assert property (
        rst_occ_reg |=> rst_occ_reg)
        else $error("reset occurred flag lost");

    a_rst_bit_busy: assert property (
        sq.busy && reg_rd && reg_addr == dev_ctrl_pkg::CTRL_OFF
        |=> reg_rdata[dev_ctrl_pkg::CTRL_DRST_BIT])
        else $error("device reset bit read zero while sequence runs");

    a_irq_cleared: assert property (
        reg_wr && reg_addr == dev_ctrl_pkg::IRQ_CLR_OFF
        |=> (irq_stat_reg & $past(reg_wdata[dev_ctrl_pkg::IRQ_W-1:0]) & ~$past(irq_evt)) == '0)
        else $error("interrupt cause survived a clear");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    c_global_reset: cover property (dev_start && device_reset_permit ##[1:30] sq.done);
    c_local_reset: cover property (dev_start && !device_reset_permit);
    c_tx_paused: cover property (tx_paused_flag_reg ##[1:50] !tx_paused_flag_reg);
    c_irq_raised: cover property ($rose(irq));
    c_set_wins: cover property (xoff_rcvd && flow_ctrl_active && (xon_rcvd || pause_expired));
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Signals
    logic        clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        permit;
    logic        duplex;
    logic        phy_mode;
    logic        link_pin;
    logic        fc_on;
    logic [2:0]  evt;
    logic        whole_device_reset_bit;
    logic        phy_reset_bit;
    logic        strip;
    logic        irq;
    logic [31:0] lfsr;
    logic [31:0] r;
    logic [31:0] d;
    logic [3:0]  step;
    int          cnt;
    int          mismatches;
    int          num_checks;

    // Steps of {flow control, pause expired, xon, xoff} and paused flag after each
    localparam logic [27:0] TX_STEPS = 28'h9a9cbc1;
    localparam logic [6:0]  TX_EXP   = 7'b1010100;

    device_ctrl_status_bits i_dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .device_reset_permit (permit),
        .mac_full_duplex     (duplex),
        .internal_phy_mode   (phy_mode),
        .phy_link_pin        (link_pin),
        .flow_ctrl_active    (fc_on),
        .xoff_rcvd           (evt[0]),
        .xon_rcvd            (evt[1]),
        .pause_expired       (evt[2]),
        .dev_reset_out       (whole_device_reset_bit),
        .phy_reset_out       (phy_reset_bit),
        .tag_strip_out       (strip),
        .irq                 (irq)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction

    function automatic logic [31:0] exp_status(input logic dup, input logic lnk,
                                               input logic txo, input logic occ);
        return {20'h0, occ, 6'h0, txo, 2'h0, lnk, dup};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic ev(input logic [2:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 3'h0;
    endtask

    task automatic count_reset(input int n);
        cnt = 0;
        #1 cnt += whole_device_reset_bit;
        repeat (n) begin
            @(posedge clk);
            #1 cnt += whole_device_reset_bit;
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
        permit = 1'b0; duplex = 1'b0; phy_mode = 1'b0; link_pin = 1'b0; fc_on = 1'b0;
        evt = 3'h0; lfsr = 32'h17fb; mismatches = 0; num_checks = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1 check("outputs after reset", {28'h0, whole_device_reset_bit, phy_reset_bit, strip, irq}, 32'h0);
        rd(dev_ctrl_pkg::CTRL_OFF, d);
        check("control after reset", d, 32'h0);
        rd(dev_ctrl_pkg::IRQ_EN_OFF, d);
        check("irq enable after reset", d, 32'h0);
        // Random control, duplex and link, with writes to read-only and unmapped places
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            r = lfsr & 32'hc000_0001;
            wr(dev_ctrl_pkg::CTRL_OFF, r);
            wr(dev_ctrl_pkg::STATUS_OFF, lfsr & 32'hffff_ffd3);
            wr(8'h44, lfsr);
            duplex   <= lfsr[3];
            phy_mode <= lfsr[5];
            link_pin <= lfsr[7];
            repeat (6) @(posedge clk);
            #1 check("tag strip", {31'h0, strip}, {31'h0, r[30]});
            check("phy reset", {31'h0, phy_reset_bit}, {31'h0, r[31]});
            rd(dev_ctrl_pkg::CTRL_OFF, d);
            check("control", d & 32'hc000_0001, r);
            rd(dev_ctrl_pkg::STATUS_OFF, d);
            check("status", d & 32'h0813, exp_status(lfsr[3], lfsr[5] & lfsr[7] & r[0], 1'b0, 1'b0));
            rd(8'h44, d);
            check("unmapped", d, 32'h0);
        end
        wr(dev_ctrl_pkg::CTRL_OFF, 32'h0000_0001);
        phy_mode <= 1'b1;
        link_pin <= 1'b1;
        // Pause flag: set, clear by xon, clear by expiry, set wins, no flow control
        for (int k = 0; k < 7; k++) begin
            step = TX_STEPS[27 - 4 * k -: 4];
            fc_on <= step[3];
            ev(step[2:0]);
            rd(dev_ctrl_pkg::STATUS_OFF, d);
            check("tx paused", {31'h0, d[4]}, {31'h0, TX_EXP[6 - k]});
        end
        // Interrupt masked, enabled, cleared
        #1 check("irq masked", {31'h0, irq}, 32'h0);
        wr(dev_ctrl_pkg::IRQ_EN_OFF, 32'h4);
        repeat (3) @(posedge clk);
        #1 check("irq raised", {31'h0, irq}, 32'h1);
        rd(dev_ctrl_pkg::IRQ_STAT_OFF, d);
        check("irq pause cause", d & 32'h4, 32'h4);
        wr(dev_ctrl_pkg::IRQ_CLR_OFF, 32'h4);
        repeat (3) @(posedge clk);
        #1 check("irq cleared", {31'h0, irq}, 32'h0);
        // Device reset without permit
        permit <= 1'b0;
        wr(dev_ctrl_pkg::CTRL_OFF, 32'h6000_0001);
        rd(dev_ctrl_pkg::CTRL_OFF, d);
        check("reset bit busy", {31'h0, d[29]}, 32'h1);
        count_reset(24);
        check("unpermitted reset cycles", 32'(cnt), 32'h0);
        rd(dev_ctrl_pkg::CTRL_OFF, d);
        check("control after reset", d & 32'he000_0001, 32'h4000_0001);
        rd(dev_ctrl_pkg::STATUS_OFF, d);
        check("status reset flag", d & 32'h0813, exp_status(duplex, 1'b1, 1'b0, 1'b1));
        rd(dev_ctrl_pkg::IRQ_STAT_OFF, d);
        check("irq reset cause", d & 32'h1, 32'h1);
        // Device reset with permit
        permit <= 1'b1;
        wr(dev_ctrl_pkg::CTRL_OFF, 32'he000_0001);
        count_reset(27);
        check("global reset cycles", 32'(cnt), 32'(dev_ctrl_pkg::RESET_HOLD_CYC));
        check("outputs after global", {29'h0, strip, phy_reset_bit, irq}, 32'h0);
        rd(dev_ctrl_pkg::CTRL_OFF, d);
        check("control after global", d & 32'he000_0001, 32'h0);
        rd(dev_ctrl_pkg::IRQ_EN_OFF, d);
        check("irq enable after global", d, 32'h0);
        rd(dev_ctrl_pkg::STATUS_OFF, d);
        check("status after global", d & 32'h0813, exp_status(duplex, 1'b0, 1'b0, 1'b1));
        close_out();
    end
endmodule
